// file: hsps_defs.vh
`ifndef HSPS_DEFS_VH
`define HSPS_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define HSPS_CLK_HZ 100000000
`define HSPS_I2C_MAX_HZ 400000
`define HSPS_SPI_MAX_HZ 2500000
// Quarter-bit divisors, rounded up so the bus never runs above its ceiling
`define HSPS_I2C_QDIV ((`HSPS_CLK_HZ + 4 * `HSPS_I2C_MAX_HZ - 1) / (4 * `HSPS_I2C_MAX_HZ))
`define HSPS_SPI_QDIV ((`HSPS_CLK_HZ + 4 * `HSPS_SPI_MAX_HZ - 1) / (4 * `HSPS_SPI_MAX_HZ))

// ****************************************
// Frame constants
// ****************************************
`define HSPS_I2C_ADDR_WR 8'h70
`define HSPS_I2C_ADDR_RD 8'h71
`define HSPS_SPI_DIR_WR 8'h00
`define HSPS_SPI_DIR_RD 8'h01
`define HSPS_SPI_HDR_LAST 6'h17
`define HSPS_SEL_ADDR 16'hEBFF
`define HSPS_SEL_LAST_STEP 2'h2
`define HSPS_LOCK_STEP 2'h3

// ****************************************
// Second configuration register
// ****************************************
`define HSPS_CFG2_ADDR 16'h0000
`define HSPS_CFG2_LOCK_BIT 1
`define HSPS_CFG2_WIDTH 2'h0

`endif

// file: hsps_tick.v
`timescale 1ns/100ps
`default_nettype none

module hsps_tick #(
  parameter DIV = 10,
  parameter W = 8
) (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Control
  input wire run,
  // Enable pulse
  output reg tick
);
  localparam integer LAST_I = DIV - 1;
  localparam [W-1:0] LAST = LAST_I[W-1:0];
  reg [W-1:0] cnt_q;

  always @(posedge mclk) begin
    if (sys_rst || !run) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= {W{1'b0}};
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick <= 1'b0;
    end
  end
endmodule // hsps_tick

`default_nettype wire

// file: hsps_host.v
// Behaviour
// - Host selects SPI by three SPI writes to an unused address like 0xEBFF.
// - On I2C, host sets bit 1 of second configuration register to lock.
// - I2C clock at most 400 kHz over open-drain shared lines.
// - I2C write: start, 0x70, 16-bit register address, then value.
// - Host issues stop after the final value byte is acknowledged.
// - Addresses and values travel most significant bit first.
// - I2C read stage one: start, 0x70, 16-bit address, no stop.
// - Stage two: repeated start, 0x71, device returns bytes MSB first.
// - Host acknowledges each read byte except last, then nack and stop.
// - SPI: sample on rising clock, change on falling clock, MSB first.
// - SPI clock at most 2.5 MHz.
// - Select low for whole SPI transfer; rising select aborts it.
// - Host should read back written registers to verify them.
// - SPI frame starts with direction byte, bit 0 high for read.
// - SPI write sends address and value with no skipped clock cycle.
`timescale 1ns/100ps
`default_nettype none
`include "hsps_defs.vh"

module hsps_host #(
  parameter [15:0] CFG2_ADDR = `HSPS_CFG2_ADDR,
  parameter [1:0] CFG2_WIDTH = `HSPS_CFG2_WIDTH,
  parameter [31:0] CFG2_VALUE = 32'h00000001 << `HSPS_CFG2_LOCK_BIT,
  parameter I2C_QDIV = `HSPS_I2C_QDIV,
  parameter SPI_QDIV = `HSPS_SPI_QDIV
) (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Port choice
  input wire useSpi,
  output wire portReady,
  output wire spiActive,
  // Command
  input wire cmdValid,
  output wire cmdReady,
  input wire cmdRead,
  input wire [15:0] cmdAddr,
  input wire [1:0] cmdWidth,
  input wire [31:0] cmdData,
  // Response
  output reg rspValid,
  output reg [31:0] rspData,
  output reg rspErr,
  // Shared clock pin
  input wire clkIn,
  output wire clkOut,
  output wire clkOe,
  // Shared data pin
  input wire datIn,
  output wire datOut,
  output wire datOe,
  // SPI output and select
  input wire misoIn,
  output wire selN
);
  // ****************************************
  // States
  // ****************************************
  localparam [2:0] ST_BOOT = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_I2C_START = 3'h2;
  localparam [2:0] ST_I2C_BYTE = 3'h3;
  localparam [2:0] ST_I2C_STOP = 3'h4;
  localparam [2:0] ST_SPI_BIT = 3'h5;
  localparam [2:0] ST_SPI_END = 3'h6;
  localparam [2:0] ST_FINISH = 3'h7;

  reg [2:0] stateQ;
  reg [1:0] phaseQ;
  reg [5:0] bitQ;
  reg [2:0] byteQ;
  reg [2:0] nBytesQ;
  reg readQ;
  reg stage2Q;
  reg isCmdQ;
  reg [55:0] shQ;
  reg [31:0] rxQ;
  reg sclQ;
  reg sdaQ;
  reg ssNQ;
  reg ackErrQ;
  reg [1:0] bootStepQ;
  reg bootDoneQ;
  reg spiModeQ;

  // ****************************************
  // Quarter-bit enables
  // ****************************************
  wire i2cTick;
  wire spiTick;
  wire busy = (stateQ != ST_IDLE) && (stateQ != ST_BOOT);

  hsps_tick #(.DIV(I2C_QDIV), .W(8)) u_i2c_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(busy && !spiModeQ),
    .tick(i2cTick)
  );

  hsps_tick #(.DIV(SPI_QDIV), .W(8)) u_spi_tick (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .run(busy && spiModeQ),
    .tick(spiTick)
  );

  // Slave holding SCL low stretches the low phase
  wire stretch = !spiModeQ && sclQ && !clkIn;
  wire adv = (spiModeQ ? spiTick : i2cTick) && !stretch;

  // ****************************************
  // Operation launch
  // ****************************************
  wire bootOp = !bootDoneQ;
  wire lockOp = (bootStepQ == `HSPS_LOCK_STEP);
  wire launch = (stateQ == ST_IDLE) && (bootOp || cmdValid);
  wire opRead = bootOp ? 1'b0 : cmdRead;
  // Select toggles by dummy writes, then the lock write
  wire [15:0] opAddr = bootOp ? (lockOp ? CFG2_ADDR : `HSPS_SEL_ADDR) : cmdAddr;
  wire [1:0] opWidth = bootOp ? (lockOp ? CFG2_WIDTH : 2'h0) : cmdWidth;
  wire [31:0] opData = bootOp ? (lockOp ? CFG2_VALUE : 32'h00000000) : cmdData;
  wire [7:0] dirByte = !spiModeQ ? `HSPS_I2C_ADDR_WR :
                       (opRead ? `HSPS_SPI_DIR_RD : `HSPS_SPI_DIR_WR);
  reg [2:0] opBytes;
  reg [31:0] opAligned;

  // Left-align value so it leaves MSB first
  always @* begin
    case (opWidth)
      2'h0: begin
        opBytes = 3'h1;
        opAligned = {opData[7:0], 24'h000000};
      end
      2'h1: begin
        opBytes = 3'h2;
        opAligned = {opData[15:0], 16'h0000};
      end
      default: begin
        opBytes = 3'h4;
        opAligned = opData;
      end
    endcase
  end

  assign cmdReady = (stateQ == ST_IDLE) && bootDoneQ;
  assign portReady = bootDoneQ;
  assign spiActive = spiModeQ;

  // ****************************************
  // Pin drive
  // ****************************************
  // SPI lines push-pull, I2C lines open-drain
  assign clkOut = spiModeQ ? sclQ : 1'b0;
  assign clkOe = spiModeQ ? 1'b1 : !sclQ;
  assign datOut = spiModeQ ? sdaQ : 1'b0;
  assign datOe = spiModeQ ? 1'b1 : !sdaQ;
  assign selN = ssNQ;

  wire rxMode = stage2Q && (byteQ != 3'h0);
  wire lastRx = (byteQ == nBytesQ);
  wire [5:0] spiLast = `HSPS_SPI_HDR_LAST + {nBytesQ, 3'h0};

  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge mclk) begin
    if (sys_rst) begin
      stateQ <= ST_BOOT;
      phaseQ <= 2'h0;
      bitQ <= 6'h00;
      byteQ <= 3'h0;
      nBytesQ <= 3'h1;
      readQ <= 1'b0;
      stage2Q <= 1'b0;
      isCmdQ <= 1'b0;
      shQ <= 56'h00000000000000;
      rxQ <= 32'h00000000;
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
      ssNQ <= 1'b1;
      ackErrQ <= 1'b0;
      bootStepQ <= 2'h0;
      bootDoneQ <= 1'b0;
      spiModeQ <= 1'b0;
      rspValid <= 1'b0;
      rspData <= 32'h00000000;
      rspErr <= 1'b0;
    end else begin
      rspValid <= 1'b0;
      case (stateQ)
        ST_BOOT: begin
          spiModeQ <= useSpi;
          bootStepQ <= useSpi ? 2'h0 : `HSPS_LOCK_STEP;
          stateQ <= ST_IDLE;
        end
        ST_IDLE: begin
          if (launch) begin
            readQ <= opRead;
            nBytesQ <= opBytes;
            isCmdQ <= !bootOp;
            shQ <= {dirByte, opAddr, opAligned};
            rxQ <= 32'h00000000;
            ackErrQ <= 1'b0;
            stage2Q <= 1'b0;
            byteQ <= 3'h0;
            bitQ <= 6'h00;
            phaseQ <= 2'h0;
            if (spiModeQ) begin
              ssNQ <= 1'b0;
              stateQ <= ST_SPI_BIT;
            end else begin
              stateQ <= ST_I2C_START;
            end
          end
        end
        ST_I2C_START: begin
          if (adv) begin
            phaseQ <= phaseQ + 2'h1;
            case (phaseQ)
              2'h0: sdaQ <= 1'b1;
              2'h1: sclQ <= 1'b1;
              2'h2: sdaQ <= 1'b0;
              default: begin
                sclQ <= 1'b0;
                bitQ <= 6'h00;
                stateQ <= ST_I2C_BYTE;
              end
            endcase
          end
        end
        ST_I2C_BYTE: begin
          if (adv) begin
            phaseQ <= phaseQ + 2'h1;
            case (phaseQ)
              2'h0: begin
                if (bitQ != 6'h08)
                  sdaQ <= rxMode ? 1'b1 : shQ[55];
                else
                  sdaQ <= rxMode ? lastRx : 1'b1;
              end
              2'h1: sclQ <= 1'b1;
              2'h2: begin
                if (bitQ != 6'h08 && rxMode)
                  rxQ <= {rxQ[30:0], datIn};
                if (bitQ == 6'h08 && !rxMode && datIn)
                  ackErrQ <= 1'b1;
              end
              default: begin
                sclQ <= 1'b0;
                if (bitQ != 6'h08) begin
                  bitQ <= bitQ + 6'h01;
                  shQ <= {shQ[54:0], 1'b0};
                end else begin
                  bitQ <= 6'h00;
                  if (ackErrQ) begin
                    stateQ <= ST_I2C_STOP;
                  end else if (!readQ && byteQ == nBytesQ + 3'h2) begin
                    stateQ <= ST_I2C_STOP;
                  end else if (readQ && !stage2Q && byteQ == 3'h2) begin
                    stage2Q <= 1'b1;
                    byteQ <= 3'h0;
                    shQ[55:48] <= `HSPS_I2C_ADDR_RD;
                    stateQ <= ST_I2C_START;
                  end else if (readQ && stage2Q && lastRx) begin
                    stateQ <= ST_I2C_STOP;
                  end else begin
                    byteQ <= byteQ + 3'h1;
                  end
                end
              end
            endcase
          end
        end
        ST_I2C_STOP: begin
          if (adv) begin
            phaseQ <= phaseQ + 2'h1;
            case (phaseQ)
              2'h0: sdaQ <= 1'b0;
              2'h1: sclQ <= 1'b1;
              2'h2: sdaQ <= 1'b1;
              default: stateQ <= ST_FINISH;
            endcase
          end
        end
        ST_SPI_BIT: begin
          if (adv) begin
            phaseQ <= phaseQ + 2'h1;
            case (phaseQ)
              2'h0: begin
                sclQ <= 1'b0;
                sdaQ <= shQ[55];
              end
              2'h1: sclQ <= 1'b0;
              2'h2: begin
                sclQ <= 1'b1;
                if (readQ && bitQ > `HSPS_SPI_HDR_LAST)
                  rxQ <= {rxQ[30:0], misoIn};
              end
              default: begin
                shQ <= {shQ[54:0], 1'b0};
                if (bitQ == spiLast)
                  stateQ <= ST_SPI_END;
                else
                  bitQ <= bitQ + 6'h01;
              end
            endcase
          end
        end
        ST_SPI_END: begin
          if (adv) begin
            phaseQ <= phaseQ + 2'h1;
            if (phaseQ == 2'h3) begin
              ssNQ <= 1'b1;
              sdaQ <= 1'b1;
              stateQ <= ST_FINISH;
            end
          end
        end
        ST_FINISH: begin
          // One quarter bit of bus idle before the next frame
          if (adv) begin
            stateQ <= ST_IDLE;
            phaseQ <= 2'h0;
            if (isCmdQ) begin
              rspValid <= 1'b1;
              rspData <= rxQ;
              rspErr <= ackErrQ;
            end
            if (!bootDoneQ) begin
              if (lockOp)
                bootDoneQ <= 1'b1;
              else
                bootStepQ <= bootStepQ + 2'h1;
            end
          end
        end
        default: stateQ <= ST_IDLE;
      endcase
    end
  end
endmodule // hsps_host

`default_nettype wire

// file: placeholder_unused.v
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: hsps_host_props.sv
`timescale 1ns/100ps
`default_nettype none
// ********
// Port checker
// ********
module hsps_host_props #(
  parameter SPI_QDIV = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Observed ports
  input wire logic useSpi,
  input wire logic portReady,
  input wire logic spiActive,
  input wire logic rspValid,
  input wire logic clkOut,
  input wire logic clkOe,
  input wire logic datOut,
  input wire logic datOe,
  input wire logic selN
);
  int loCnt = 0;
  int falls = 0;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  // Low-phase length and select falls since reset
  always @(posedge mclk) begin
    loCnt <= clkOut ? 0 : loCnt + 1;
    falls <= sys_rst ? 0 : falls + int'($fell(selN));
  end

  property p_i2cSelHigh;
    !spiActive |-> selN;
  endproperty
  a_i2cSelHigh: assert property (p_i2cSelHigh) else $error("select low in two-wire mode");

  property p_i2cOpenDrain;
    !spiActive |-> !(clkOe && clkOut) && !(datOe && datOut);
  endproperty
  a_i2cOpenDrain: assert property (p_i2cOpenDrain) else $error("two-wire line driven high");

  property p_mosiOnFall;
    spiActive && !selN && $stable(selN) && $changed(datOut) |-> $fell(clkOut);
  endproperty
  a_mosiOnFall: assert property (p_mosiOnFall) else $error("data moved off falling clock");

  property p_sclkLow;
    spiActive && !selN && $rose(clkOut) |-> loCnt >= 2 * SPI_QDIV;
  endproperty
  a_sclkLow: assert property (p_sclkLow) else $error("serial clock too fast");

  property p_sclkInFrame;
    spiActive && $fell(clkOut) |-> !selN;
  endproperty
  a_sclkInFrame: assert property (p_sclkInFrame) else $error("clock pulse outside frame");

  property p_portHeld;
    portReady |=> portReady && $stable(spiActive);
  endproperty
  a_portHeld: assert property (p_portHeld) else $error("port choice changed");

  property p_bootFalls;
    $rose(portReady) |-> falls == (spiActive ? 4 : 0);
  endproperty
  a_bootFalls: assert property (p_bootFalls) else $error("wrong select toggle count at boot");

  property p_selMode;
    portReady |-> spiActive == useSpi;
  endproperty
  a_selMode: assert property (p_selMode) else $error("port differs from request");

  c_spiRsp: cover property (rspValid && spiActive);
  c_i2cRsp: cover property (rspValid && !spiActive);
  c_spiBoot: cover property ($rose(portReady) && spiActive);
endmodule // hsps_host_props
`default_nettype wire

// file: hsps_dev.sv
`timescale 1ns/100ps
`default_nettype none
`include "hsps_defs.vh"
// ********
// Behavioural metering device, host port only
// ********
module hsps_dev (
  // Clock and reset
  input wire logic mclk,
  input wire logic sysRst,
  // Bus lines
  input wire logic scl,
  input wire logic sda,
  input wire logic selN,
  input wire logic nack,
  output var logic sdaPull,
  output wire logic miso
);
  logic [31:0] mem [0:15];
  logic [5:0] wid [0:15];
  logic [55:0] sIn;
  logic [31:0] rdv, wv;
  logic [15:0] ptr;
  logic [7:0] sh;
  logic rdMode = 0, locked = 0, misoEn = 0, misoBit = 0;
  int falls = 0, sb = 0, bitCnt = 0, byteCnt = 0, nb = 0, rdIdx = -1;
  wire logic spiMode = falls >= 3;
  wire logic tx = rdMode && byteCnt > 0;

  // Never carries capture data; idles on inverse of last bit
  assign miso = misoEn ? misoBit : !misoBit;

  task automatic commit(input logic [31:0] v, input int n);
    mem[ptr[3:0]] = v & 32'((64'h1 << n) - 1);
    wid[ptr[3:0]] = n[5:0];
    if (ptr == `HSPS_CFG2_ADDR && (spiMode || v[`HSPS_CFG2_LOCK_BIT])) locked = 1;
  endtask

  always @(posedge mclk) begin
    if (sysRst) begin
      falls = 0;
      locked = 0;
      misoEn = 0;
      sdaPull = 0;
      for (int i = 0; i < 16; i++) begin
        mem[i] = 32'h0;
        wid[i] = 6'h20;
      end
    end
  end

  always @(negedge selN) begin
    if (!locked) falls++;
    sb = 0;
  end

  always @(posedge selN) begin
    misoEn = 0;
    if (spiMode && sb > 24 && !rdMode) commit(sIn[31:0], sb - 24);
  end

  always @(negedge sda) begin
    if (!spiMode && selN && scl) begin
      bitCnt = 0;
      byteCnt = 0;
      nb = 0;
      rdMode = 0;
    end
  end

  always @(posedge sda) begin
    if (!spiMode && selN && scl && nb > 0) commit(wv, nb);
  end

  always @(posedge scl) begin
    if (spiMode && !selN) begin
      sIn = {sIn[54:0], sda};
      sb++;
      if (sb == 24) begin
        ptr = sIn[15:0];
        rdMode = sIn[16];
        rdv = mem[ptr[3:0]];
        rdIdx = int'(wid[ptr[3:0]]) - 1;
      end
    end else if (!spiMode && selN) begin
      if (bitCnt < 8) begin
        sh = {sh[6:0], sda};
        bitCnt++;
        if (bitCnt == 8 && byteCnt == 0) rdMode = sh[0];
      end else begin
        bitCnt = 0;
        if (rdMode && byteCnt == 0) begin
          rdv = mem[ptr[3:0]];
          rdIdx = int'(wid[ptr[3:0]]) - 1;
        end else if (!rdMode && byteCnt == 1) ptr[15:8] = sh;
        else if (!rdMode && byteCnt == 2) ptr[7:0] = sh;
        else if (!rdMode && byteCnt > 2) begin
          wv = {wv[23:0], sh};
          nb += 8;
        end
        byteCnt++;
      end
    end
  end

  always @(negedge scl) begin
    if (spiMode && !selN && rdMode && sb >= 24 && rdIdx >= 0) begin
      misoEn = 1;
      misoBit = rdv[rdIdx];
      rdIdx--;
    end else if (!spiMode && selN) begin
      if (bitCnt == 8) sdaPull = !tx && !nack && (byteCnt > 0 || sh[7:1] == 7'h38);
      else if (tx && rdIdx >= 0) begin
        sdaPull = !rdv[rdIdx];
        rdIdx--;
      end else sdaPull = 0;
    end
  end
endmodule // hsps_dev
`default_nettype wire

// file: host_serial_port_select_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin \
  num_checks++; \
  if ((a) !== (b)) begin \
    n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); \
  end \
end
module host_serial_port_select_tb;
  logic mclk = 0, sys_rst = 1, useSpi = 0, cmdValid = 0, cmdRead = 0, nack = 0, gotErr;
  logic [15:0] cmdAddr = 16'h0;
  logic [1:0] cmdWidth = 2'h0;
  logic [31:0] cmdData = 32'h0, got;
  wire logic portReady, spiActive, cmdReady, rspValid, rspErr, clkOut, clkOe, datOut, datOe, selN, sdaPull, miso;
  wire logic [31:0] rspData;
  wire logic sclW = clkOe ? clkOut : 1'b1;
  wire logic sdaW = (datOe ? datOut : 1'b1) && !sdaPull;
  int n_errors = 0, num_checks = 0, cyc = 0;

  always #5 mclk = ~mclk;

  hsps_host #(.I2C_QDIV(4), .SPI_QDIV(2)) dut_u (.mclk(mclk), .sys_rst(sys_rst), .useSpi(useSpi),
    .portReady(portReady), .spiActive(spiActive), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead),
    .cmdAddr(cmdAddr), .cmdWidth(cmdWidth), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
    .rspErr(rspErr), .clkIn(sclW), .clkOut(clkOut), .clkOe(clkOe), .datIn(sdaW), .datOut(datOut),
    .datOe(datOe), .misoIn(miso), .selN(selN));
  hsps_dev dev_u (.mclk(mclk), .sysRst(sys_rst), .scl(sclW), .sda(sdaW), .selN(selN), .nack(nack),
    .sdaPull(sdaPull), .miso(miso));

  task automatic complete_run();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic boot(input logic spi);
    @(negedge mclk);
    sys_rst = 1;
    useSpi = spi;
    repeat (10) @(negedge mclk);
    sys_rst = 0;
    for (int i = 0; i < 20000 && portReady !== 1'b1; i++) @(negedge mclk);
    `CHK(portReady, 1'b1)
    `CHK(spiActive, spi)
    `CHK(dev_u.spiMode, spi)
    `CHK(dev_u.locked, 1'b1)
    $display("boot done spi=%0d", spi);
  endtask

  task automatic xfer(input logic rd, input logic [15:0] addr, input logic [1:0] w, input logic [31:0] d);
    cmdRead = rd;
    cmdAddr = addr;
    cmdWidth = w;
    cmdData = d;
    cmdValid = 1;
    for (int i = 0; i < 5000 && cmdReady !== 1'b1; i++) @(negedge mclk);
    @(negedge mclk);
    cmdValid = 0;
    `CHK(cmdReady, 1'b0)
    for (int i = 0; i < 5000 && rspValid !== 1'b1; i++) @(negedge mclk);
    `CHK(rspValid, 1'b1)
    got = rspData;
    gotErr = rspErr;
  endtask

  task automatic rw_widths();
    logic [31:0] e;
    for (int k = 0; k < 3; k++) begin
      e = k == 0 ? 32'h000000D4 : k == 1 ? 32'h0000A5D4 : 32'h9E17A5D4;
      xfer(1'b0, 16'h5A31 + 16'(k), 2'(k), 32'h9E17A5D4);
      `CHK(gotErr, 1'b0)
      `CHK(dev_u.mem[k + 1], e)
      xfer(1'b1, 16'h5A31 + 16'(k), 2'(k), 32'h0);
      `CHK(got, e)
    end
    $display("write and read done spi=%0d", spiActive);
  endtask

  task automatic nack_write();
    nack = 1;
    xfer(1'b0, 16'h5A34, 2'h2, 32'h12345678);
    `CHK(gotErr, 1'b1)
    `CHK(dev_u.mem[4], 32'h0)
    nack = 0;
    xfer(1'b1, 16'h5A33, 2'h2, 32'h0);
    `CHK(got, 32'h9E17A5D4)
    $display("refused write done");
  endtask

  initial begin
    boot(1'b1);
    rw_widths();
    boot(1'b0);
    rw_widths();
    nack_write();
    complete_run();
  end
endmodule // host_serial_port_select_tb
bind hsps_host hsps_host_props #(.SPI_QDIV(SPI_QDIV)) props_u (.mclk(mclk), .sys_rst(sys_rst), .useSpi(useSpi),
  .portReady(portReady), .spiActive(spiActive), .rspValid(rspValid), .clkOut(clkOut), .clkOe(clkOe),
  .datOut(datOut), .datOe(datOe), .selN(selN));
`default_nettype wire
